/* File: logic/rtclk_cfg.svh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the lookup access port files
`ifndef RTCLK_CFG_SVH
`define RTCLK_CFG_SVH

`define RTCLK_IDX_PTR        16'h2887
`define RTCLK_IDX_DAT        16'h2888
`define RTCLK_IDX_STB        16'h2889
`define RTCLK_ADDR_PTR       18'h0A21C
`define RTCLK_ADDR_DAT       18'h0A220
`define RTCLK_ADDR_STB       18'h0A224
`define RTCLK_PTR_MSB        6
`define RTCLK_STEP_BIT       7
`define RTCLK_FETCH_BIT      1
`define RTCLK_STORE_BIT      0
`define RTCLK_RST_PTR        8'h00
`define RTCLK_RST_DAT        8'h00
`define RTCLK_RST_STB        2'h0
`define RTCLK_RAM_WORDS      128
`define RTCLK_RAM_LAT        2'h2

`endif

/* File: logic/rtclk_pkg.sv */
// Types shared by the lookup access port files
// Assumes the cfg header supplies all numeric constants
package rtclk_pkg;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [17:0] addr;
    logic [31:0] wdata;
  } rtclk_apb_req_s;

  typedef struct packed {
    logic       go;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rtclk_ram_req_s;

  typedef enum logic [1:0] {
    RTCLK_IDLE,
    RTCLK_BUSY,
    RTCLK_DONE
  } rtclk_state_e;

endpackage : rtclk_pkg

/* File: logic/rtclk_ram.sv */
// Lookup RAM of 128 bytes with single-cycle synchronous read
// Assumes one request pulse at a time from the access sequencer
`timescale 1ns/1ps
`include "rtclk_cfg.svh"

module rtclk_ram (
  input  wire logic                    pclk,
  input  wire logic                    pclken,
  input  wire rtclk_pkg::rtclk_ram_req_s req,
  output logic [7:0]                   rdata
);

  logic [7:0] mem_q [`RTCLK_RAM_WORDS];
  logic [7:0] rdata_q;

  // No reset on the array: contents survive a port reset
  always_ff @(posedge pclk) begin
    if (pclken && req.go) begin
      if (req.wr) begin
        mem_q[req.addr] <= req.wdata;
      end
      rdata_q <= mem_q[req.addr];
    end
  end

  assign rdata = rdata_q;

endmodule : rtclk_ram

/* File: logic/rtclk_seq.sv */
// Sequencer that runs one lookup RAM operation and signals completion
// Assumes start pulses only while idle
`timescale 1ns/1ps
`include "rtclk_cfg.svh"

module rtclk_seq (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pclken,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  rtclk_pkg::rtclk_state_e state_q;
  rtclk_pkg::rtclk_state_e state_d;
  logic [1:0]              cnt_q;
  logic [1:0]              cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      rtclk_pkg::RTCLK_IDLE: begin
        if (start) begin
          state_d = rtclk_pkg::RTCLK_BUSY;
          cnt_d   = `RTCLK_RAM_LAT;
        end
      end
      rtclk_pkg::RTCLK_BUSY: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = rtclk_pkg::RTCLK_DONE;
        end
      end
      rtclk_pkg::RTCLK_DONE: begin
        state_d = rtclk_pkg::RTCLK_IDLE;
      end
      default: state_d = rtclk_pkg::RTCLK_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rtclk_pkg::RTCLK_IDLE;
      cnt_q   <= 2'h0;
    end else if (pclken) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy = (state_q != rtclk_pkg::RTCLK_IDLE);
  assign done = (state_q == rtclk_pkg::RTCLK_DONE) && pclken;

endmodule : rtclk_seq

/* File: logic/rtclk_port.sv */
// Contract
// R1: A 7-bit pointer selects the lookup RAM location for reads and writes.
// R2: With step flag set, pointer advances by one per strobe.
// R3: The advanced pointer reads back through the pointer field.
// R4: An 8-bit data register carries the byte written or read.
// R5: Software sets fetch or store strobe; device runs it with pointer, data.
// R6: A set strobe stays set until its operation completes.
// R7: On completion strobe clears; pointer steps only if step flag set.
// R8: Fetch loads data from pre-step address; store writes data there.
//
// APB slave for the lookup RAM access port, top of the block
// Assumes a single pclk domain and a well-behaved APB master
`timescale 1ns/1ps
`include "rtclk_cfg.svh"

module rtclk_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclken,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  function automatic logic [1:0] reg_sel(input logic [17:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a == `RTCLK_ADDR_PTR) s = 2'h0;
    if (a == `RTCLK_ADDR_DAT) s = 2'h1;
    if (a == `RTCLK_ADDR_STB) s = 2'h2;
    return s;
  endfunction : reg_sel

  // Pointer and step flag share one register and one reset value
  localparam logic [7:0] rst_ptr_reg = `RTCLK_RST_PTR;

  rtclk_pkg::rtclk_apb_req_s apb;
  rtclk_pkg::rtclk_ram_req_s ram_req;

  logic [6:0]  ptr_q;
  logic [6:0]  ptr_d;
  logic        step_q;
  logic        step_d;
  logic [7:0]  dat_q;
  logic [7:0]  dat_d;
  logic [1:0]  stb_q;
  logic [1:0]  stb_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        busy;
  logic        done;
  logic        start;
  logic [7:0]  ram_rdata;
  logic        acc;
  logic        wr_acc;
  logic [1:0]  sel;

  assign apb.sel   = psel;
  assign apb.en    = penable;
  assign apb.wr    = pwrite;
  assign apb.addr  = paddr;
  assign apb.wdata = pwdata;

  // Zero-wait slave: read data is captured in setup so that it stands
  // from flip-flops for the whole access cycle
  assign acc    = apb.sel && !apb.en && pclken;
  // Writes land only at the access edge, where the master sees pready
  assign wr_acc = apb.sel && apb.en && apb.wr && pclken;
  assign sel = reg_sel(apb.addr);

  // Start an operation when a strobe is newly set while idle
  assign start = (stb_q != 2'h0) && !busy && !done;

  assign ram_req.go    = start && pclken;                 // R5
  assign ram_req.wr    = stb_q[`RTCLK_STORE_BIT];         // R8
  assign ram_req.addr  = ptr_q;                           // R1
  assign ram_req.wdata = dat_q;                           // R4

  rtclk_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .pclken  (pclken),
    .start   (start),
    .busy    (busy),
    .done    (done)
  );

  rtclk_ram u_ram (
    .pclk   (pclk),
    .pclken (pclken),
    .req    (ram_req),
    .rdata  (ram_rdata)
  );

  always_comb begin
    ptr_d     = ptr_q;
    step_d    = step_q;
    dat_d     = dat_q;
    stb_d     = stb_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (acc) begin
      pslverr_d = (sel == 2'h3);
      prdata_d  = 32'h0;
      unique case (sel)
        2'h0: prdata_d = {24'h0, step_q, ptr_q};          // R3
        2'h1: prdata_d = {24'h0, dat_q};                  // R4
        2'h2: prdata_d = {30'h0, stb_q};                  // R6
        default: prdata_d = 32'h0;
      endcase
    end
    if (wr_acc) begin
      unique case (sel)
        2'h0: begin
          ptr_d  = apb.wdata[`RTCLK_PTR_MSB:0];            // R1
          step_d = apb.wdata[`RTCLK_STEP_BIT];
        end
        2'h1: dat_d = apb.wdata[7:0];                      // R4
        // Writing zero cannot cancel a running operation
        2'h2: stb_d = stb_q | apb.wdata[1:0];              // R5 R6
        default: ;
      endcase
    end
    // Completion clears the strobes, but a strobe that software sets in
    // the same cycle survives and starts the next operation
    if (done) begin
      stb_d = (wr_acc && sel == 2'h2) ? apb.wdata[1:0] : 2'h0;  // R7
      if (stb_q[`RTCLK_FETCH_BIT] && !stb_q[`RTCLK_STORE_BIT]) begin
        dat_d = ram_rdata;                                 // R8
      end
      if (step_q) begin
        ptr_d = ptr_q + 7'h1;                              // R2 R7
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q     <= rst_ptr_reg[`RTCLK_PTR_MSB:0];
      step_q    <= rst_ptr_reg[`RTCLK_STEP_BIT];
      dat_q     <= `RTCLK_RST_DAT;
      stb_q     <= `RTCLK_RST_STB;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (pclken) begin
      ptr_q     <= ptr_d;
      step_q    <= step_d;
      dat_q     <= dat_d;
      stb_q     <= stb_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q && apb.sel && apb.en;

endmodule : rtclk_port

/* File: test/rtclk_port_sva.sv */
// Checker for the lookup access port, seen from its APB pins
// Assumes a bind onto rtclk_port; the bus stands still while pclken is low
`timescale 1ns/1ps
`include "rtclk_cfg.svh"

module rtclk_port_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       sa = psel && !penable;
  wire       ac = psel && penable;
  wire [7:0] wb = pwdata[7:0];
  wire       ip = paddr == `RTCLK_ADDR_PTR;
  wire       id = paddr == `RTCLK_ADDR_DAT;
  wire       is = paddr == `RTCLK_ADDR_STB;

  chk_ptr_back:
    assert property (ac && pwrite && ip ##1 sa && !pwrite && ip
      |=> prdata[7:0] == $past(wb, 2)) else $error("pointer readback");
  chk_dat_back:
    assert property (ac && pwrite && id ##1 sa && !pwrite && id
      |=> prdata[7:0] == $past(wb, 2)) else $error("data readback");
  chk_stb_hold:
    assert property (ac && pwrite && is && wb[1:0] != 0 ##1 sa && !pwrite
      && is |=> prdata[1:0] != 0) else $error("strobe dropped early");
  chk_ptr_width:
    assert property (ac && !pwrite && ip |-> prdata[31:8] == 0)
      else $error("pointer upper bits");
  chk_dat_width:
    assert property (ac && !pwrite && id |-> prdata[31:8] == 0)
      else $error("data upper bits");
  chk_stb_width:
    assert property (ac && !pwrite && is |-> prdata[31:2] == 0)
      else $error("strobe upper bits");
  chk_err_unmapped:
    assert property (ac && !(ip || id || is) |-> pslverr && prdata == 0)
      else $error("unmapped access accepted");
  chk_err_mapped:
    assert property (ac && (ip || id || is) |-> pready && !pslverr)
      else $error("mapped access refused");
endmodule : rtclk_port_sva

/* File: test/rtclk_port_tb_top.sv */
// Self-checking bench for the lookup access port
// Assumes the bench is the only APB master; pclken drops only while
// the bus stands still
`timescale 1ns/1ps
`include "rtclk_cfg.svh"

module rtclk_port_tb_top;
  localparam logic [17:0] a_ptr = `RTCLK_ADDR_PTR;
  localparam logic [17:0] a_dat = `RTCLK_ADDR_DAT;
  localparam logic [17:0] a_stb = `RTCLK_ADDR_STB;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pclken = 1;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        pready, pslverr, rerr;
  int          n_errors = 0, tests_run = 0, cyc = 0;

  always #12.5 pclk = ~pclk;

  rtclk_port u_rtclk_port (.pclk(pclk), .presetn(presetn), .pclken(pclken),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task summarize;
    $display("errors %0d of %0d compares", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Psel stays up between calls so transfers run back to back
  task xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
  endtask : xfer

  task op(input logic [31:0] s);
    int k;
    xfer(1'h1, a_stb, s);
    xfer(1'h0, a_stb, 0);
    chk(rdat, s);
    for (k = 0; k < 20 && rdat !== 0; k++) xfer(1'h0, a_stb, 0);
    chk(rdat, 32'h0);
  endtask : op

  task t_reset;
    xfer(1'h0, a_ptr, 0);
    chk(rdat, {24'h0, `RTCLK_RST_PTR});
    xfer(1'h0, a_dat, 0);
    chk(rdat, {24'h0, `RTCLK_RST_DAT});
    xfer(1'h0, a_stb, 0);
    chk(rdat, {30'h0, `RTCLK_RST_STB});
    xfer(1'h0, 18'h0A228, 0);
    chk({31'h0, rerr}, 32'h1);
    $display("t_reset done");
  endtask : t_reset

  // Pointer 127 with stepping on: the step must wrap within 7 bits
  task t_store;
    xfer(1'h1, a_ptr, 32'hFF);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'hFF);
    xfer(1'h1, a_dat, 32'hA5);
    xfer(1'h0, a_dat, 0);
    chk(rdat, 32'hA5);
    op(32'h1);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'h80);
    xfer(1'h1, a_dat, 32'h3C);
    op(32'h1);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'h81);
    $display("t_store done");
  endtask : t_store

  task t_fetch;
    xfer(1'h1, a_ptr, 32'h7F);
    op(32'h2);
    xfer(1'h0, a_dat, 0);
    chk(rdat, 32'hA5);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'h7F);
    xfer(1'h1, a_ptr, 32'h80);
    op(32'h2);
    xfer(1'h0, a_dat, 0);
    chk(rdat, 32'h3C);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'h81);
    $display("t_fetch done");
  endtask : t_fetch

  // With pclken low the fetch must stand well past its usual completion
  task t_freeze;
    int k;
    xfer(1'h1, a_ptr, 32'h7F);
    xfer(1'h1, a_stb, 32'h2);
    pclken <= 0;
    repeat (8) @(posedge pclk);
    pclken <= 1;
    xfer(1'h0, a_stb, 0);
    chk(rdat, 32'h2);
    for (k = 0; k < 20 && rdat !== 0; k++) xfer(1'h0, a_stb, 0);
    chk(rdat, 32'h0);
    xfer(1'h0, a_dat, 0);
    chk(rdat, 32'hA5);
    xfer(1'h0, a_ptr, 0);
    chk(rdat, 32'h7F);
    $display("t_freeze done");
  endtask : t_freeze

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize;
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_store;
    t_fetch;
    t_freeze;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    summarize;
  end
endmodule : rtclk_port_tb_top

bind rtclk_port rtclk_port_sva u_rtclk_port_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
